// ==== verilog/bcr_reg.v ====
// Overview of operation
// - 32-bit software register; writable fields clear to zero on power-on reset.
// - manual reset and standby leave the register contents untouched.
// - bit 31 captures the byte-order strap at power-on; read-only.
// - bit 30 captures the role strap inverted at power-on; read-only.
// - bit 29 captures the area 0 type strap inverted; read-only.
// - reserved bits 28,27,23,22,18,1 read zero; software writes zero there.
// - bit 26 set turns data pin pull-ups off; zero turns them on.
// - no data pull-up during a bus access or while the bus is released.
// - bit 25 set turns control input pin pull-ups off.
// - bit 24 set turns off pull-ups on high-impedance control output pins.
// - bit 21 selects area 1 byte control; multiplexed setting overrides it.
// - bit 20 selects area 4 byte control; multiplexed setting overrides it.
`timescale 1ns/1ps
`include "bcr_consts.vh"
module bcr_reg #(
  parameter ADDR_W = `BCR_ADDR_W
) (
  // clock and power-on reset
  input wire clk,
  input wire reset_n,
  // manual reset pin, does not clear the register
  input wire manual_reset_n,
  // standby indication from the power controller
  input wire standby,
  // mode straps sampled after power-on reset
  input wire byte_order_strap,
  input wire role_strap,
  input wire area0_type_strap,
  // bus state from the bus controller
  input wire bus_access_active,
  input wire bus_released,
  input wire output_pins_hiz,
  input wire area1_multiplexed_bus_interface,
  input wire area4_multiplexed_bus_interface,
  // avalon-mm slave
  input wire [ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [`BCR_DATA_W-1:0] writedata,
  input wire [`BCR_BE_W-1:0] byteenable,
  output reg [`BCR_DATA_W-1:0] readdata,
  output reg waitrequest,
  // decoded controls
  output reg [`BCR_DATA_W-1:0] bus_control_register_1,
  output reg little_endian,
  output reg slave_mode,
  output reg area0_mux_type_flag,
  output reg data_pin_pullup_en,
  output reg input_pin_pullup_en,
  output reg output_pin_pullup_en,
  output reg area1_byte_ctrl_mode,
  output reg area4_byte_ctrl_mode
);

  localparam [2:0] ST_INIT = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_ACK = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] settle_cnt;
  reg [2:0] strap_bits;
  reg [`BCR_DATA_W-1:0] rw_bits;
  reg [`BCR_DATA_W-1:0] next_rw_bits;
  reg [`BCR_DATA_W-1:0] reg_value;
  reg [`BCR_DATA_W-1:0] rd_value;
  wire [2:0] strap_sync;
  wire [1:0] ctl_sync;
  wire manual_reset_sync_n;
  wire standby_sync;
  wire hit;
  wire req;
  integer i;
  reg next_waitrequest;
  reg [`BCR_DATA_W-1:0] next_readdata;
  reg next_data_pullup_en;
  reg next_input_pullup_en;
  reg next_output_pullup_en;
  reg next_area1_byte_ctrl_mode;
  reg next_area4_byte_ctrl_mode;
  localparam [`BCR_DATA_W-1:0] WMASK = `BCR_WRITE_MASK;

  // pins cross into the clock domain through two flip-flops
  bcr_sync #(
    .WIDTH(3),
    .INIT(3'h0)
  ) u_strap_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({byte_order_strap, role_strap, area0_type_strap}),
    .sync_out(strap_sync)
  );

  bcr_sync #(
    .WIDTH(2),
    .INIT(2'h1)
  ) u_ctl_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({standby, manual_reset_n}),
    .sync_out(ctl_sync)
  );

  assign manual_reset_sync_n = ctl_sync[0];
  assign standby_sync = ctl_sync[1];
  assign hit = (address == `BCR_BUS_CTRL_1_OFFSET);
  assign req = read | write;

  // straps are caught once after each power-on release; manual resets never recapture
  // the count covers the two synchroniser edges before the straps are trusted
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt <= 2'h0;
    end else if (state == ST_INIT) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_bits <= 3'h0;
    end else if (state == ST_INIT && settle_cnt == `BCR_STRAP_SETTLE) begin
      strap_bits[2] <= strap_sync[2];
      strap_bits[1] <= ~strap_sync[1];
      strap_bits[0] <= ~strap_sync[0];
    end
  end

  // full register image; strap and reserved positions never come from rw_bits
  always @* begin
    reg_value = rw_bits & `BCR_WRITE_MASK;
    reg_value[`BCR_BIT_BYTE_ORDER] = strap_bits[2];
    reg_value[`BCR_BIT_ROLE] = strap_bits[1];
    reg_value[`BCR_BIT_AREA0_MUX] = strap_bits[0];
  end

  always @* begin
    if (hit) begin
      rd_value = reg_value;
    end else begin
      rd_value = {`BCR_DATA_W{1'b0}};
    end
  end

  // byte-lane merge; only writable bits take the new value
  always @* begin
    next_rw_bits = rw_bits;
    for (i = 0; i < `BCR_BE_W; i = i + 1) begin
      if (byteenable[i]) begin
        next_rw_bits[8*i +: 8] = (writedata[8*i +: 8] & WMASK[8*i +: 8])
          | (rw_bits[8*i +: 8] & ~WMASK[8*i +: 8]);
      end
    end
  end

  // only power-on reset clears the writable fields; manual reset and standby do not
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rw_bits <= `BCR_RESET_VALUE;
    end else if (state == ST_ACK && write && hit) begin
      rw_bits <= next_rw_bits;
    end
  end

  // slave handshake: request waits in idle, answer stands for one cycle
  always @* begin
    case (state)
      ST_INIT: begin
        if (settle_cnt == `BCR_STRAP_SETTLE) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_INIT;
        end
      end
      ST_IDLE: begin
        if (req) begin
          next_state = ST_ACK;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // manual reset only restarts the handshake, the register is kept
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_INIT;
    end else if (!manual_reset_sync_n && state != ST_INIT) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // answer of the slave handshake; read data stands through the acknowledge cycle
  always @* begin
    next_waitrequest = (next_state != ST_ACK);
    next_readdata = `BCR_RESET_VALUE;
    if (!manual_reset_sync_n && state != ST_INIT) begin
      next_waitrequest = 1'b1;
    end else if (state == ST_IDLE && read) begin
      next_readdata = rd_value;
    end else if (state == ST_ACK) begin
      next_readdata = readdata;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= next_waitrequest;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= `BCR_RESET_VALUE;
    end else begin
      readdata <= next_readdata;
    end
  end

  // pull-ups are kept off until the straps are in, and held through standby
  always @* begin
    next_data_pullup_en = 1'b0;
    next_input_pullup_en = 1'b0;
    next_output_pullup_en = 1'b0;
    if (state != ST_INIT) begin
      next_data_pullup_en = !reg_value[`BCR_BIT_DATA_PU_OFF];
      if (bus_access_active || bus_released) begin
        next_data_pullup_en = 1'b0;
      end
      next_input_pullup_en = !reg_value[`BCR_BIT_INPUT_PU_OFF];
      next_output_pullup_en = output_pins_hiz
        && !reg_value[`BCR_BIT_OUTPUT_PU_OFF];
    end
  end

  // a multiplexed area overrides its byte control selection
  always @* begin
    next_area1_byte_ctrl_mode = reg_value[`BCR_BIT_AREA1_BYTE_CTRL]
      && !area1_multiplexed_bus_interface;
    next_area4_byte_ctrl_mode = reg_value[`BCR_BIT_AREA4_BYTE_CTRL]
      && !area4_multiplexed_bus_interface;
  end

  // image is kept through standby; only power-on reset clears it
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_control_register_1 <= `BCR_RESET_VALUE;
    end else if (standby_sync) begin
      bus_control_register_1 <= reg_value;
    end else begin
      bus_control_register_1 <= reg_value;
    end
  end

  // strap flags mirror the captured bits
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      little_endian <= 1'b0;
    end else begin
      little_endian <= reg_value[`BCR_BIT_BYTE_ORDER];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slave_mode <= 1'b0;
    end else begin
      slave_mode <= reg_value[`BCR_BIT_ROLE];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      area0_mux_type_flag <= 1'b0;
    end else begin
      area0_mux_type_flag <= reg_value[`BCR_BIT_AREA0_MUX];
    end
  end

  // pull-up enables
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_pin_pullup_en <= 1'b0;
    end else begin
      data_pin_pullup_en <= next_data_pullup_en;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      input_pin_pullup_en <= 1'b0;
    end else begin
      input_pin_pullup_en <= next_input_pullup_en;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      output_pin_pullup_en <= 1'b0;
    end else begin
      output_pin_pullup_en <= next_output_pullup_en;
    end
  end

  // area byte control modes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      area1_byte_ctrl_mode <= 1'b0;
    end else begin
      area1_byte_ctrl_mode <= next_area1_byte_ctrl_mode;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      area4_byte_ctrl_mode <= 1'b0;
    end else begin
      area4_byte_ctrl_mode <= next_area4_byte_ctrl_mode;
    end
  end

endmodule

// ==== pkg/bcr_consts.vh ====
`ifndef BCR_CONSTS_VH
`define BCR_CONSTS_VH

// register bus geometry
`define BCR_ADDR_W 4
`define BCR_DATA_W 32
`define BCR_BE_W 4

// register offset (byte address)
`define BCR_BUS_CTRL_1_OFFSET 4'h0

// field positions
`define BCR_BIT_BYTE_ORDER 31
`define BCR_BIT_ROLE 30
`define BCR_BIT_AREA0_MUX 29
`define BCR_BIT_DATA_PU_OFF 26
`define BCR_BIT_INPUT_PU_OFF 25
`define BCR_BIT_OUTPUT_PU_OFF 24
`define BCR_BIT_AREA1_BYTE_CTRL 21
`define BCR_BIT_AREA4_BYTE_CTRL 20

// access masks and reset value
`define BCR_WRITE_MASK 32'h073b_fffd
`define BCR_RESERVED_MASK 32'h18c4_0002
`define BCR_STRAP_MASK 32'he000_0000
`define BCR_RESET_VALUE 32'h0000_0000

// cycles the strap synchroniser needs before capture
`define BCR_STRAP_SETTLE 2'h3

`endif

// ==== verilog/bcr_sync.v ====
`timescale 1ns/1ps
module bcr_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // asynchronous level in, synchronous level out
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ==== test/bcr_reg_sva.sv ====
`timescale 1ns/1ps
`include "bcr_consts.vh"
module bcr_reg_sva (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // bus state
  input wire bus_access_active,
  input wire bus_released,
  input wire output_pins_hiz,
  input wire area1_multiplexed_bus_interface,
  input wire area4_multiplexed_bus_interface,
  // avalon-mm slave
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  // decoded controls
  input wire [31:0] bus_control_register_1,
  input wire little_endian,
  input wire slave_mode,
  input wire area0_mux_type_flag,
  input wire data_pin_pullup_en,
  input wire input_pin_pullup_en,
  input wire output_pin_pullup_en,
  input wire area1_byte_ctrl_mode,
  input wire area4_byte_ctrl_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_wr_ack;
    write && !waitrequest && address == 4'h0 && byteenable == 4'hf;
  endsequence
  sequence s_rd_ack;
    read && !waitrequest && address == 4'h0;
  endsequence
  a_write_masked: assert property (
    s_wr_ack |=> ##1 bus_control_register_1 == (($past(writedata, 2) & `BCR_WRITE_MASK) |
    ($past(bus_control_register_1, 2) & ~`BCR_WRITE_MASK))) else $error("write mask broken");
  a_wait_pulse: assert property (
    !waitrequest |=> waitrequest) else $error("waitrequest low too long");
  a_read_image: assert property (
    s_rd_ack |-> readdata == bus_control_register_1) else $error("read data wrong");
  a_reserved_zero: assert property (
    ((readdata | bus_control_register_1) & `BCR_RESERVED_MASK) == 32'h0) else $error("reserved set");
  a_strap_flags: assert property (
    {little_endian, slave_mode, area0_mux_type_flag} == bus_control_register_1[31:29])
    else $error("strap flags differ");
  a_data_pullup: assert property (
    data_pin_pullup_en |-> !bus_control_register_1[26] && !$past(bus_access_active) &&
    !$past(bus_released)) else $error("data pull-up wrong");
  a_input_pullup: assert property (
    !waitrequest |-> input_pin_pullup_en == !bus_control_register_1[25])
    else $error("input pull-up wrong");
  a_output_pullup: assert property (
    !waitrequest |-> output_pin_pullup_en == ($past(output_pins_hiz) &&
    !bus_control_register_1[24])) else $error("output pull-up wrong");
  a_area1_mode: assert property (
    area1_byte_ctrl_mode == (bus_control_register_1[21] &&
    !$past(area1_multiplexed_bus_interface))) else $error("area1 mode wrong");
  a_area4_mode: assert property (
    area4_byte_ctrl_mode == (bus_control_register_1[20] &&
    !$past(area4_multiplexed_bus_interface))) else $error("area4 mode wrong");
endmodule
bind bcr_reg bcr_reg_sva u_sva (.*);

// ==== test/bus_control_config_register_bench.sv ====
`timescale 1ns/1ps
module bus_control_config_register_bench;
  reg clk = 1'h0;
  reg reset_n = 1'h0;
  reg manual_reset_n = 1'h1;
  reg standby = 1'h0;
  // byte order, role, area 0 type
  reg [2:0] strap = 3'h5;
  // access, released, hiz, area1 mux, area4 mux
  reg [4:0] bus = 5'h0;
  reg [3:0] address = 4'h0;
  reg read = 1'h0;
  reg write = 1'h0;
  reg [31:0] writedata = 32'h0;
  reg [3:0] byteenable = 4'h0;
  wire [31:0] readdata;
  wire waitrequest;
  wire [31:0] image;
  wire [7:0] ctl;
  reg [31:0] q;
  integer err_total = 0;
  integer checked = 0;
  integer cycles = 0;
  integer tnum = 1;
  bcr_reg u_dut (.clk(clk), .reset_n(reset_n), .manual_reset_n(manual_reset_n),
    .standby(standby), .byte_order_strap(strap[2]), .role_strap(strap[1]),
    .area0_type_strap(strap[0]), .bus_access_active(bus[4]), .bus_released(bus[3]),
    .output_pins_hiz(bus[2]), .area1_multiplexed_bus_interface(bus[1]),
    .area4_multiplexed_bus_interface(bus[0]), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .bus_control_register_1(image), .little_endian(ctl[7]),
    .slave_mode(ctl[6]), .area0_mux_type_flag(ctl[5]), .data_pin_pullup_en(ctl[4]),
    .input_pin_pullup_en(ctl[3]), .output_pin_pullup_en(ctl[2]),
    .area1_byte_ctrl_mode(ctl[1]), .area4_byte_ctrl_mode(ctl[0]));
  initial begin
    forever #4 clk = ~clk;
  end
  task final_report;
    begin
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_total = err_total + 1;
      final_report;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // request held until waitrequest is sampled low
  task acc(input w, input [3:0] a, input [31:0] d, input [3:0] be);
    begin
      @(posedge clk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= d;
      byteenable <= be;
      @(posedge clk);
      while (waitrequest !== 1'h0)
        @(posedge clk);
      q = readdata;
      write <= 1'h0;
      read <= 1'h0;
    end
  endtask
  task por(input [2:0] s);
    begin
      reset_n <= 1'h0;
      strap <= s;
      repeat (6) @(posedge clk);
      reset_n <= 1'h1;
    end
  endtask
  task done;
    begin
      $display("test %0d done", tnum);
      tnum = tnum + 1;
    end
  endtask
  initial begin
    por(3'h5);
    acc(0, 4'h0, 32'h0, 4'hf);
    chk(q, 32'hc000_0000);
    chk({24'h0, ctl}, 32'hd8);
    done;
    acc(1, 4'h0, 32'he73b_fffd, 4'hf);
    acc(0, 4'h0, 32'h0, 4'hf);
    chk(q, 32'hc73b_fffd);
    chk({24'h0, ctl}, 32'hc3);
    bus <= 5'h03;
    repeat (2) @(posedge clk);
    chk({24'h0, ctl}, 32'hc0);
    bus <= 5'h00;
    done;
    acc(1, 4'h0, 32'h0, 4'h8);
    acc(0, 4'h0, 32'h0, 4'hf);
    chk(q, 32'hc03b_fffd);
    manual_reset_n <= 1'h0;
    standby <= 1'h1;
    repeat (4) @(posedge clk);
    manual_reset_n <= 1'h1;
    standby <= 1'h0;
    acc(0, 4'h0, 32'h0, 4'hf);
    chk(q, 32'hc03b_fffd);
    done;
    acc(1, 4'h4, 32'h0, 4'hf);
    acc(0, 4'h4, 32'h0, 4'hf);
    chk(q, 32'h0);
    acc(1, 4'h0, 32'h0, 4'hf);
    bus <= 5'h04;
    repeat (2) @(posedge clk);
    chk({24'h0, ctl}, 32'hdc);
    bus <= 5'h10;
    repeat (2) @(posedge clk);
    chk({24'h0, ctl}, 32'hc8);
    bus <= 5'h08;
    repeat (2) @(posedge clk);
    chk({24'h0, ctl}, 32'hc8);
    done;
    por(3'h2);
    acc(0, 4'h0, 32'h0, 4'hf);
    chk(q, 32'h2000_0000);
    done;
    final_report;
  end
endmodule
